// ### core/pin_cfg_pkg.sv
// constants and types for the multifunction pin configuration block
package pin_cfg_pkg;
  // register offsets
  localparam logic [3:0] OFS_PIN1_FUNC   = 4'h0;
  localparam logic [3:0] OFS_PIN4_FUNC   = 4'h1;
  localparam logic [3:0] OFS_PIN3_FUNC   = 4'h2;
  localparam logic [3:0] OFS_AOUT_MODE   = 4'h3;
  localparam logic [3:0] OFS_DUPLEX      = 4'h4;
  localparam logic [3:0] OFS_XID_SEL     = 4'h5;
  localparam logic [3:0] OFS_STATUS      = 4'h6;
  localparam logic [3:0] OFS_PIN1_SAMPLE = 4'h7;
  localparam logic [3:0] OFS_PIN4_SAMPLE = 4'h8;
  // widths and limits
  localparam int         FUNC_W       = 3;
  localparam int         SAMPLE_W     = 16;
  localparam int         PIN3_W       = 5;
  localparam logic [2:0] FUNC_MAX     = 3'h4;
  localparam logic [4:0] PIN3_MAX     = 5'h14;
  localparam logic [1:0] AOUT_MAX     = 2'h2;
  // reset values
  localparam logic [2:0] FUNC_RST     = 3'h0;
  localparam logic [4:0] PIN3_RST     = 5'h00;
  localparam logic [1:0] AOUT_RST     = 2'h0;
  localparam logic       DUPLEX_RST   = 1'b0;
  // field positions in status
  localparam int ST_SPEED_EN   = 0;
  localparam int ST_DIR_EN     = 1;
  localparam int ST_FULLDUP_OK = 2;
  localparam int ST_ID_BIT0    = 3;
  localparam int ST_ID_BIT1    = 4;
  localparam int ST_REJECT     = 5;
  // selector values
  typedef enum logic [2:0] {
    FN_UNUSED   = 3'h0,
    FN_AIN      = 3'h1,
    FN_SELFTEST = 3'h2,
    FN_AOUT     = 3'h3,
    FN_ID_BIT   = 3'h4
  } pin_func_t;
  typedef enum logic [1:0] {
    AO_VOLTAGE = 2'h0,
    AO_CURRENT = 2'h1,
    AO_OFF     = 2'h2
  } aout_mode_t;
endpackage : pin_cfg_pkg

// ### core/pin_cfg_if.sv
// bundle between the config top and the per-pin function decoder
`timescale 1ns/1ps
interface pin_cfg_if;
  logic [2:0] func;
  logic [1:0] aout_mode;
  logic       xid_sel;
  logic       pin_level;
  logic       out_en;
  logic       sample_en;
  logic       readback;
  logic       id_bit;
  modport ctrl (output func, output aout_mode, output xid_sel, output pin_level,
                input out_en, input sample_en, input readback, input id_bit);
  modport dec  (input func, input aout_mode, input xid_sel, input pin_level,
                output out_en, output sample_en, output readback, output id_bit);
endinterface : pin_cfg_if

// ### core/pin_func_decode.sv
// combinational decode of one multifunction pin's selector
`timescale 1ns/1ps
module pin_func_decode (
  pin_cfg_if.dec p
);
  // derive pin behaviour from selector and output mode
  always_comb begin
    p.out_en    = (p.func == pin_cfg_pkg::FN_AOUT) &&
                  (p.aout_mode != pin_cfg_pkg::AO_OFF);
    p.sample_en = (p.func == pin_cfg_pkg::FN_AIN);
    p.readback  = (p.func == pin_cfg_pkg::FN_SELFTEST) &&
                  (p.aout_mode == pin_cfg_pkg::AO_VOLTAGE);
    p.id_bit    = (p.func == pin_cfg_pkg::FN_ID_BIT) && p.xid_sel &&
                  p.pin_level;
  end
endmodule : pin_func_decode

// ### core/multifunction_pin_config.sv
// register port, selectors and pin control for pins 1 and 4
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module multifunction_pin_config (
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  input  wire logic [15:0] PIN1_ADC_I,
  input  wire logic [15:0] PIN4_ADC_I,
  input  wire logic        PIN1_LEVEL_I,
  input  wire logic        PIN4_LEVEL_I,
  output logic             SPEED_OUT_EN_O,
  output logic             DIR_OUT_EN_O,
  output logic             PIN1_SAMPLE_EN_O,
  output logic             PIN4_SAMPLE_EN_O,
  output logic             SPEED_READBACK_O,
  output logic             DIR_READBACK_O,
  output logic             FULL_DUPLEX_O,
  output logic [1:0]       INSTR_ID_O,
  output logic [4:0]       PIN3_FUNC_O,
  output logic [1:0]       AOUT_MODE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  logic [2:0]  pin1_function_select_ff, nxt_pin1_function_select;
  logic [2:0]  pin4_function_select_ff, nxt_pin4_function_select;
  logic [4:0]  pin3_function_select_ff, nxt_pin3_function_select;
  logic [1:0]  analog_output_mode_ff,   nxt_analog_output_mode;
  logic        serial_duplex_select_ff, nxt_serial_duplex_select;
  logic        external_identifier_select_ff, nxt_external_identifier_select;
  logic        reject_ff,               nxt_reject;
  logic [15:0] pin1_sample_ff,          nxt_pin1_sample;
  logic [15:0] pin4_sample_ff,          nxt_pin4_sample;
  logic [15:0] rdata_ff,                nxt_rdata;
  logic [5:0]  outs_ff,                 nxt_outs;
  logic [1:0]  id_ff,                   nxt_id;

  pin_cfg_if p1 ();
  pin_cfg_if p4 ();

  // per-pin decoders
  pin_func_decode u_dec1 (.p(p1.dec));
  pin_func_decode u_dec4 (.p(p4.dec));

  assign p1.func      = pin1_function_select_ff;
  assign p1.aout_mode = analog_output_mode_ff;
  assign p1.xid_sel   = external_identifier_select_ff;
  assign p1.pin_level = PIN1_LEVEL_I;
  assign p4.func      = pin4_function_select_ff;
  assign p4.aout_mode = analog_output_mode_ff;
  assign p4.xid_sel   = external_identifier_select_ff;
  assign p4.pin_level = PIN4_LEVEL_I;

  // true when selector value legal
  function automatic logic func_ok(input logic [15:0] d);
    func_ok = (d[15:3] == 13'h0000) && (d[2:0] <= pin_cfg_pkg::FUNC_MAX);
  endfunction : func_ok

  // pins only leave full duplex free when both unused
  function automatic logic pins_idle(input logic [2:0] a, input logic [2:0] b);
    pins_idle = (a == pin_cfg_pkg::FN_UNUSED) && (b == pin_cfg_pkg::FN_UNUSED);
  endfunction : pins_idle

  logic half_duplex;
  assign half_duplex = ~serial_duplex_select_ff;

  ////////////////////////////////////////////////////////////////////////////
  // register writes and sampling
  always_comb begin
    nxt_pin1_function_select       = pin1_function_select_ff;
    nxt_pin4_function_select       = pin4_function_select_ff;
    nxt_pin3_function_select       = pin3_function_select_ff;
    nxt_analog_output_mode         = analog_output_mode_ff;
    nxt_serial_duplex_select       = serial_duplex_select_ff;
    nxt_external_identifier_select = external_identifier_select_ff;
    nxt_reject                     = reject_ff;
    nxt_pin1_sample                = pin1_sample_ff;
    nxt_pin4_sample                = pin4_sample_ff;
    // cyclic sampling of analog input or read-back
    if (p1.sample_en || p1.readback) begin
      nxt_pin1_sample = PIN1_ADC_I;
    end
    if (p4.sample_en || p4.readback) begin
      nxt_pin4_sample = PIN4_ADC_I;
    end
    if (WR_I) begin
      case (ADDR_I)
        pin_cfg_pkg::OFS_PIN1_FUNC: begin
          if (half_duplex && func_ok(WDATA_I)) begin
            nxt_pin1_function_select = WDATA_I[2:0];
          end else begin
            nxt_reject = 1'b1;
          end
        end
        pin_cfg_pkg::OFS_PIN4_FUNC: begin
          if (half_duplex && func_ok(WDATA_I)) begin
            nxt_pin4_function_select = WDATA_I[2:0];
          end else begin
            nxt_reject = 1'b1;
          end
        end
        pin_cfg_pkg::OFS_PIN3_FUNC: begin
          if (WDATA_I <= {11'h000, pin_cfg_pkg::PIN3_MAX}) begin
            nxt_pin3_function_select = WDATA_I[4:0];
          end
        end
        pin_cfg_pkg::OFS_AOUT_MODE: begin
          if (half_duplex && WDATA_I <= {14'h0000, pin_cfg_pkg::AOUT_MAX}) begin
            nxt_analog_output_mode = WDATA_I[1:0];
          end
        end
        pin_cfg_pkg::OFS_DUPLEX: begin
          // full duplex only when both pins unused
          if (!WDATA_I[0] || pins_idle(pin1_function_select_ff, pin4_function_select_ff)) begin
            nxt_serial_duplex_select = WDATA_I[0];
          end
        end
        pin_cfg_pkg::OFS_XID_SEL: begin
          nxt_external_identifier_select = WDATA_I[0];
        end
        pin_cfg_pkg::OFS_STATUS: begin
          if (WDATA_I[pin_cfg_pkg::ST_REJECT]) begin
            nxt_reject = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and outputs
  always_comb begin
    nxt_rdata = 16'h0000;
    if (RD_I) begin
      case (ADDR_I)
        pin_cfg_pkg::OFS_PIN1_FUNC:   nxt_rdata = {13'h0000, pin1_function_select_ff};
        pin_cfg_pkg::OFS_PIN4_FUNC:   nxt_rdata = {13'h0000, pin4_function_select_ff};
        pin_cfg_pkg::OFS_PIN3_FUNC:   nxt_rdata = {11'h000, pin3_function_select_ff};
        pin_cfg_pkg::OFS_AOUT_MODE:   nxt_rdata = {14'h0000, analog_output_mode_ff};
        pin_cfg_pkg::OFS_DUPLEX:      nxt_rdata = {15'h0000, serial_duplex_select_ff};
        pin_cfg_pkg::OFS_XID_SEL:     nxt_rdata = {15'h0000, external_identifier_select_ff};
        pin_cfg_pkg::OFS_STATUS:      nxt_rdata = {10'h000, reject_ff, id_ff, 
                                                   pins_idle(pin1_function_select_ff, pin4_function_select_ff),
                                                   outs_ff[1:0]};
        pin_cfg_pkg::OFS_PIN1_SAMPLE: nxt_rdata = pin1_sample_ff;
        pin_cfg_pkg::OFS_PIN4_SAMPLE: nxt_rdata = pin4_sample_ff;
        default:                      nxt_rdata = 16'h0000;
      endcase
    end
    // speed/direction outputs, sample enables, read-backs
    nxt_outs = {p4.readback, p1.readback, p4.sample_en, p1.sample_en,
                p4.out_en, p1.out_en};
    nxt_id   = {p4.id_bit, p1.id_bit};
  end

  // state registers
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      pin1_function_select_ff       <= pin_cfg_pkg::FUNC_RST;
      pin4_function_select_ff       <= pin_cfg_pkg::FUNC_RST;
      pin3_function_select_ff       <= pin_cfg_pkg::PIN3_RST;
      analog_output_mode_ff         <= pin_cfg_pkg::AOUT_RST;
      serial_duplex_select_ff       <= pin_cfg_pkg::DUPLEX_RST;
      external_identifier_select_ff <= 1'b0;
      reject_ff                     <= 1'b0;
      pin1_sample_ff                <= 16'h0000;
      pin4_sample_ff                <= 16'h0000;
      rdata_ff                      <= 16'h0000;
      outs_ff                       <= 6'h00;
      id_ff                         <= 2'h0;
    end else begin
      pin1_function_select_ff       <= nxt_pin1_function_select;
      pin4_function_select_ff       <= nxt_pin4_function_select;
      pin3_function_select_ff       <= nxt_pin3_function_select;
      analog_output_mode_ff         <= nxt_analog_output_mode;
      serial_duplex_select_ff       <= nxt_serial_duplex_select;
      external_identifier_select_ff <= nxt_external_identifier_select;
      reject_ff                     <= nxt_reject;
      pin1_sample_ff                <= nxt_pin1_sample;
      pin4_sample_ff                <= nxt_pin4_sample;
      rdata_ff                      <= nxt_rdata;
      outs_ff                       <= nxt_outs;
      id_ff                         <= nxt_id;
    end
  end

  assign RDATA_O          = rdata_ff;
  assign SPEED_OUT_EN_O   = outs_ff[0];
  assign DIR_OUT_EN_O     = outs_ff[1];
  assign PIN1_SAMPLE_EN_O = outs_ff[2];
  assign PIN4_SAMPLE_EN_O = outs_ff[3];
  assign SPEED_READBACK_O = outs_ff[4];
  assign DIR_READBACK_O   = outs_ff[5];
  assign FULL_DUPLEX_O    = serial_duplex_select_ff;
  assign INSTR_ID_O       = id_ff;
  assign PIN3_FUNC_O      = pin3_function_select_ff;
  assign AOUT_MODE_O      = analog_output_mode_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_P1_HOLD_FD: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (serial_duplex_select_ff && WR_I && ADDR_I == pin_cfg_pkg::OFS_PIN1_FUNC)
      |=> $stable(pin1_function_select_ff) && reject_ff)
    else $error("pin 1 selector changed in full duplex");
  AST_P1_HD_WRITE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (!serial_duplex_select_ff && WR_I && ADDR_I == pin_cfg_pkg::OFS_PIN1_FUNC && WDATA_I <= 16'h0004)
      |=> pin1_function_select_ff == $past(WDATA_I[2:0]))
    else $error("pin 1 write lost in half duplex");
  AST_P4_HOLD_FD: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (serial_duplex_select_ff && WR_I && ADDR_I == pin_cfg_pkg::OFS_PIN4_FUNC)
      |=> $stable(pin4_function_select_ff))
    else $error("pin 4 selector changed in full duplex");
  AST_FD_IDLE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    serial_duplex_select_ff |-> pins_idle(pin1_function_select_ff, pin4_function_select_ff))
    else $error("full duplex with pins in use");
  AST_SPEED_OUT: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ##1 SPEED_OUT_EN_O == ($past(pin1_function_select_ff) == 3'h3 && $past(analog_output_mode_ff) != 2'h2))
    else $error("speed output enable wrong");
  AST_DIR_OUT: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (pin4_function_select_ff == 3'h1) |=> !DIR_OUT_EN_O && PIN4_SAMPLE_EN_O)
    else $error("direction output not off in input mode");
  AST_P1_READBACK: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (pin1_function_select_ff == 3'h2 && analog_output_mode_ff == 2'h1) |=> !SPEED_READBACK_O)
    else $error("read-back in current mode");
  AST_ID_BITS: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (pin1_function_select_ff == 3'h4 && external_identifier_select_ff && PIN1_LEVEL_I) |=> INSTR_ID_O[0])
    else $error("identifier bit 0 not taken");
  AST_RD_LATENCY: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (RD_I && ADDR_I == pin_cfg_pkg::OFS_PIN1_SAMPLE) |=> RDATA_O == $past(pin1_sample_ff))
    else $error("sample read wrong");
  AST_P1_AIN: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (pin1_function_select_ff == 3'h1) |=> PIN1_SAMPLE_EN_O && !SPEED_OUT_EN_O)
    else $error("pin 1 analog input mode wrong");
  AST_P1_SAMPLE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (pin1_function_select_ff == 3'h1) |=> pin1_sample_ff == $past(PIN1_ADC_I))
    else $error("pin 1 converter result not taken");
  AST_P4_SAMPLE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (pin4_function_select_ff == 3'h1) |=> pin4_sample_ff == $past(PIN4_ADC_I))
    else $error("pin 4 converter result not taken");
  AST_P1_RB_ON: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (pin1_function_select_ff == 3'h2 && analog_output_mode_ff == 2'h0) |=> SPEED_READBACK_O)
    else $error("speed read-back missing in voltage mode");
  AST_P4_READBACK: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (pin4_function_select_ff == 3'h2 && analog_output_mode_ff == 2'h1) |=> !DIR_READBACK_O)
    else $error("direction read-back in current mode");
  AST_P4_HD_WRITE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (!serial_duplex_select_ff && WR_I && ADDR_I == pin_cfg_pkg::OFS_PIN4_FUNC && WDATA_I <= 16'h0004)
      |=> pin4_function_select_ff == $past(WDATA_I[2:0]))
    else $error("pin 4 write lost in half duplex");
  AST_P4_REJECT: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (serial_duplex_select_ff && WR_I && ADDR_I == pin_cfg_pkg::OFS_PIN4_FUNC) |=> reject_ff)
    else $error("pin 4 full duplex write not flagged");
  AST_DIR_OUT_ON: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (pin4_function_select_ff == 3'h3 && analog_output_mode_ff != 2'h2) |=> DIR_OUT_EN_O)
    else $error("direction output not driven");
  AST_ID_BIT1: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (pin4_function_select_ff == 3'h4 && external_identifier_select_ff && PIN4_LEVEL_I) |=> INSTR_ID_O[1])
    else $error("identifier bit 1 not taken");
  AST_ID_OFF: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !external_identifier_select_ff |=> INSTR_ID_O == 2'h0)
    else $error("identifier bits without external select");
  AST_AOUT_OFF: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (analog_output_mode_ff == 2'h2) |=> !SPEED_OUT_EN_O && !DIR_OUT_EN_O)
    else $error("analog output driven while switched off");
  AST_AOUT_FD: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (serial_duplex_select_ff && WR_I && ADDR_I == pin_cfg_pkg::OFS_AOUT_MODE)
      |=> $stable(analog_output_mode_ff))
    else $error("output mode changed in full duplex");
  AST_PIN3_FREE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (WR_I && ADDR_I == pin_cfg_pkg::OFS_PIN3_FUNC && WDATA_I <= 16'h0014)
      |=> pin3_function_select_ff == $past(WDATA_I[4:0]))
    else $error("pin 3 write lost");
  AST_RD_IDLE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !RD_I |=> RDATA_O == 16'h0000)
    else $error("read data without read strobe");
  // main scenarios reached
  COV_FD: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(serial_duplex_select_ff));
  COV_REJ: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(reject_ff));
  COV_SPEED: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(SPEED_OUT_EN_O));
  COV_ID: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(INSTR_ID_O[1]));
  COV_RB: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(SPEED_READBACK_O));
endmodule : multifunction_pin_config

// ### bench/pin_env_model.sv
// analog and digital surroundings of pins 1 and 4
`timescale 1ns/1ps
module pin_env_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        pin1_sample_en_i,
  input  wire logic        pin4_sample_en_i,
  input  wire logic        speed_readback_i,
  input  wire logic        dir_readback_i,
  input  wire logic [1:0]  id_level_i,
  input  wire logic [15:0] ain_code_i,
  output logic      [15:0] pin1_adc_o,
  output logic      [15:0] pin4_adc_o,
  output logic             pin1_level_o,
  output logic             pin4_level_o
);
  logic [15:0] churn_ff;
  logic [15:0] nxt_churn;
  //////////////////////////////////////////////////////////////////////////
  // changing pattern for lines that nobody drives
  always_comb begin
    nxt_churn = ~churn_ff;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      churn_ff <= 16'h5a5a;
    end else begin
      churn_ff <= nxt_churn;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // converter codes only while sampling, otherwise meaningless
  assign pin1_adc_o = pin1_sample_en_i ? ain_code_i : churn_ff;
  assign pin4_adc_o = pin4_sample_en_i ? {ain_code_i[7:0], ain_code_i[15:8]} : churn_ff;
  // pins left open during read-back show no stable level
  assign pin1_level_o = speed_readback_i ? churn_ff[0] : id_level_i[0];
  assign pin4_level_o = dir_readback_i ? churn_ff[1] : id_level_i[1];
endmodule : pin_env_model

// ### bench/tb_top.sv
// self-checking bench for the multifunction pin configuration
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_b, wr, rd, spd_en, dir_en, s1, s4, rb1, rb4, fdx, lv1, lv4;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, adc1, adc4, code;
  logic [1:0]  id_out, aout, id_lvl;
  logic [4:0]  pin3;
  int          err_count, cmp_count, cyc;
  logic [3:0]  exp_v [5] = '{4'h0, 4'h4, 4'h2, 4'h8, 4'h1};
  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end
  multifunction_pin_config i_multifunction_pin_config (.CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PIN1_ADC_I(adc1), .PIN4_ADC_I(adc4),
    .PIN1_LEVEL_I(lv1), .PIN4_LEVEL_I(lv4), .SPEED_OUT_EN_O(spd_en), .DIR_OUT_EN_O(dir_en),
    .PIN1_SAMPLE_EN_O(s1), .PIN4_SAMPLE_EN_O(s4), .SPEED_READBACK_O(rb1), .DIR_READBACK_O(rb4),
    .FULL_DUPLEX_O(fdx), .INSTR_ID_O(id_out), .PIN3_FUNC_O(pin3), .AOUT_MODE_O(aout));
  pin_env_model i_pin_env_model (.clk_i(clk), .rst_b_i(rst_b), .pin1_sample_en_i(s1),
    .pin4_sample_en_i(s4), .speed_readback_i(rb1), .dir_readback_i(rb4), .id_level_i(id_lvl),
    .ain_code_i(code), .pin1_adc_o(adc1), .pin4_adc_o(adc4), .pin1_level_o(lv1), .pin4_level_o(lv4));
  //////////////////////////////////////////////////////////////////////////
  // register port cycles and compares
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk_val(rdata, exp);
  endtask : rd_chk
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {wr, rd, rst_b} = 3'b000;
    addr = 4'h0; wdata = 16'h0000; code = 16'hffff; id_lvl = 2'b11;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // reset contents, unmapped index last
    for (int a = 0; a < 10; a++) begin
      rd_chk((a == 9) ? 4'hf : 4'(a), (a == 6) ? 16'h0004 : 16'h0000);
    end
    wr_reg(pin_cfg_pkg::OFS_XID_SEL, 16'h0001);
    // every selector value on both pins, voltage output mode
    for (int m = 0; m < 5; m++) begin
      wr_reg(pin_cfg_pkg::OFS_PIN1_FUNC, 16'(m));
      settle();
      chk_val({12'h000, spd_en, s1, rb1, id_out[0]}, {12'h000, exp_v[m]});
      rd_chk(pin_cfg_pkg::OFS_PIN1_FUNC, 16'(m));
      wr_reg(pin_cfg_pkg::OFS_PIN1_FUNC, 16'h0000);
      wr_reg(pin_cfg_pkg::OFS_PIN4_FUNC, 16'(m));
      settle();
      chk_val({12'h000, dir_en, s4, rb4, id_out[1]}, {12'h000, exp_v[m]});
      rd_chk(pin_cfg_pkg::OFS_PIN4_FUNC, 16'(m));
      wr_reg(pin_cfg_pkg::OFS_PIN4_FUNC, 16'h0000);
    end
    // current output: no read-back, analog drive still allowed
    wr_reg(pin_cfg_pkg::OFS_AOUT_MODE, 16'h0001);
    wr_reg(pin_cfg_pkg::OFS_PIN1_FUNC, 16'h0002);
    settle();
    chk_val({14'h0000, rb1, aout == 2'h1}, 16'h0001);
    wr_reg(pin_cfg_pkg::OFS_PIN1_FUNC, 16'h0003);
    settle();
    chk_val({15'h0000, spd_en}, 16'h0001);
    // out-of-range selector refused, flag set then cleared
    wr_reg(pin_cfg_pkg::OFS_PIN1_FUNC, 16'h0005);
    rd_chk(pin_cfg_pkg::OFS_PIN1_FUNC, 16'h0003);
    rd_chk(pin_cfg_pkg::OFS_STATUS, 16'h0021);
    wr_reg(pin_cfg_pkg::OFS_PIN1_FUNC, 16'h0000);
    wr_reg(pin_cfg_pkg::OFS_STATUS, 16'h0020);
    rd_chk(pin_cfg_pkg::OFS_STATUS, 16'h0004);
    // full duplex refused while a pin is in use
    wr_reg(pin_cfg_pkg::OFS_PIN4_FUNC, 16'h0001);
    wr_reg(pin_cfg_pkg::OFS_DUPLEX, 16'h0001);
    settle();
    chk_val({15'h0000, fdx}, 16'h0000);
    wr_reg(pin_cfg_pkg::OFS_PIN4_FUNC, 16'h0000);
    // outputs switched off, allowed in half duplex with both pins idle
    wr_reg(pin_cfg_pkg::OFS_AOUT_MODE, 16'h0002);
    settle();
    chk_val({14'h0000, aout}, 16'h0002);
    wr_reg(pin_cfg_pkg::OFS_AOUT_MODE, 16'h0000);
    // full duplex: pin 1/4 writes rejected, pin 3 still free
    wr_reg(pin_cfg_pkg::OFS_DUPLEX, 16'h0001);
    settle();
    chk_val({15'h0000, fdx}, 16'h0001);
    wr_reg(pin_cfg_pkg::OFS_PIN1_FUNC, 16'h0003);
    wr_reg(pin_cfg_pkg::OFS_PIN4_FUNC, 16'h0003);
    wr_reg(pin_cfg_pkg::OFS_PIN3_FUNC, 16'h0014);
    wr_reg(pin_cfg_pkg::OFS_AOUT_MODE, 16'h0001);
    settle();
    chk_val({9'h000, spd_en, dir_en, pin3}, 16'h0014);
    rd_chk(pin_cfg_pkg::OFS_PIN1_FUNC, 16'h0000);
    rd_chk(pin_cfg_pkg::OFS_PIN4_FUNC, 16'h0000);
    rd_chk(pin_cfg_pkg::OFS_STATUS, 16'h0024);
    rd_chk(pin_cfg_pkg::OFS_AOUT_MODE, 16'h0000);
    wr_reg(pin_cfg_pkg::OFS_DUPLEX, 16'h0000);
    // analog input results, top code and a mixed code
    wr_reg(pin_cfg_pkg::OFS_PIN1_FUNC, 16'h0001);
    wr_reg(pin_cfg_pkg::OFS_PIN4_FUNC, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      code <= (k == 0) ? 16'hffff : 16'h12f0;
      settle();
      rd_chk(pin_cfg_pkg::OFS_PIN1_SAMPLE, (k == 0) ? 16'hffff : 16'h12f0);
      rd_chk(pin_cfg_pkg::OFS_PIN4_SAMPLE, (k == 0) ? 16'hffff : 16'hf012);
    end
    // identifier bits follow pin levels, only with external select
    wr_reg(pin_cfg_pkg::OFS_PIN1_FUNC, 16'h0004);
    wr_reg(pin_cfg_pkg::OFS_PIN4_FUNC, 16'h0004);
    id_lvl <= 2'b10;
    settle();
    chk_val({14'h0000, id_out}, 16'h0002);
    rd_chk(pin_cfg_pkg::OFS_STATUS, 16'h0030);
    wr_reg(pin_cfg_pkg::OFS_XID_SEL, 16'h0000);
    // oversized pin 3 and output mode values ignored
    wr_reg(pin_cfg_pkg::OFS_PIN3_FUNC, 16'h0015);
    wr_reg(pin_cfg_pkg::OFS_AOUT_MODE, 16'h0003);
    settle();
    chk_val({9'h000, aout, pin3}, 16'h0014);
    chk_val({14'h0000, id_out}, 16'h0000);
    summarize();
  end
endmodule : tb_top
